//--- bim_consts.svh
// Overview of operation
// - bus master reads and writes all eight registers
// - direction, address, write data latched at select
// - register access ends with clocked acknowledge
// - enabled request drives its programmed level line
// - shared level stays until all sources served
// - level zero never drives any request line
// - acknowledge latches level and compares pending sources
// - no daisy input means no response at all
// - no match passes the daisy chain on
// - daisy output held until acknowledge negated
// - internal match drives vector and acknowledge
// - highest numbered source wins on shared level
// - internal answer also shows code and strobe
// - vector and acknowledge held until acknowledge ends
// - external match gives strobe and code only
// - auto clear drops source enable on acknowledge
// - requests frozen once acknowledge cycle starts
// - flag bits never change interrupt behaviour
// - flag auto clear clears flag on acknowledge
// - select plus acknowledge for two cycles resets
// - reset zeroes control, vectors get uninitialised value
// - control bit five selects external response
// - control bit three is enable auto clear
// - control bit six is flag auto clear
`ifndef BIM_CONSTS_SVH
`define BIM_CONSTS_SVH

// control register field positions
`define BIM_LVL_LSB      0
`define BIM_LVL_W        3
`define BIM_AUTO_CLR_BIT 3
`define BIM_SRC_EN_BIT   4
`define BIM_EXT_SEL_BIT  5
`define BIM_FLAG_AC_BIT  6
`define BIM_FLAG_BIT     7

// reset values
`define BIM_CTRL_RST     8'h00
`define BIM_VEC_RST      8'h0F

// register index layout: bit 2 picks vector bank
`define BIM_VEC_BANK_BIT 2

// timing counts in clock cycles
`define BIM_RST_CYCLES   2

// synchroniser word and its idle value (all lines negated)
`define BIM_SYNC_W       19
`define BIM_SYNC_IDLE    19'h7FFFF

`endif

//--- bim_pkg.sv
package bim_pkg;

	// sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE    = 7'h01,
		ST_ACCESS  = 7'h02,
		ST_ACCDONE = 7'h04,
		ST_WAITIN  = 7'h08,
		ST_PASS    = 7'h10,
		ST_CODE    = 7'h20,
		ST_RESPOND = 7'h40
	} bim_state_type;

	// byte held in one register
	typedef logic [7:0] bim_byte_type;

endpackage

//--- bim_reg_if.sv
`timescale 1ns/1ps
// register file access between sequencer and storage
interface bim_reg_if;
	logic                  wr_en;     // one-cycle write pulse
	logic [2:0]            wr_idx;    // register index
	bim_pkg::bim_byte_type wr_data;   // write byte
	logic                  rd_en;     // one-cycle read pulse
	logic [2:0]            rd_idx;    // read index
	bim_pkg::bim_byte_type rd_data;   // registered read byte
	logic                  soft_rst;  // bus-made reset level
	logic                  ack_clr;   // auto clear pulse
	logic [1:0]            ack_src;   // source being served
	logic [31:0]           ctrl_flat; // four control bytes
	logic [31:0]           vec_flat;  // four vector bytes

	modport store (input wr_en, wr_idx, wr_data, rd_en, rd_idx, soft_rst,
		ack_clr, ack_src, output rd_data, ctrl_flat, vec_flat);
	modport user (output wr_en, wr_idx, wr_data, rd_en, rd_idx, soft_rst,
		ack_clr, ack_src, input rd_data, ctrl_flat, vec_flat);
endinterface

//--- bim_regs.sv
`timescale 1ns/1ps
`include "bim_consts.svh"
// eight byte registers: four control, four vector
module bim_regs (
	input wire logic mclk,
	input wire logic arst_n,
	bim_reg_if.store rif
);
	bim_pkg::bim_byte_type ctrl_q [0:3]; // control bytes
	bim_pkg::bim_byte_type vec_q  [0:3]; // vector bytes
	bim_pkg::bim_byte_type rd_q;         // read data register

	////////////////////////////////////////////////////////////////////////////
	// control registers: write, auto clear, bus reset
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int s = 0; s < 4; s++) ctrl_q[s] <= `BIM_CTRL_RST;
		end else if (rif.soft_rst) begin
			for (int s = 0; s < 4; s++) ctrl_q[s] <= `BIM_CTRL_RST;
		end else if (rif.wr_en && !rif.wr_idx[`BIM_VEC_BANK_BIT]) begin
			ctrl_q[rif.wr_idx[1:0]] <= rif.wr_data;
		end else if (rif.ack_clr) begin
			// flag bits are only touched here and by bus writes or reset, never read by the request path
			if (ctrl_q[rif.ack_src][`BIM_AUTO_CLR_BIT])
				ctrl_q[rif.ack_src][`BIM_SRC_EN_BIT] <= 1'b0;
			if (ctrl_q[rif.ack_src][`BIM_FLAG_AC_BIT])
				ctrl_q[rif.ack_src][`BIM_FLAG_BIT] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// vector registers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int s = 0; s < 4; s++) vec_q[s] <= `BIM_VEC_RST;
		end else if (rif.soft_rst) begin
			for (int s = 0; s < 4; s++) vec_q[s] <= `BIM_VEC_RST;
		end else if (rif.wr_en && rif.wr_idx[`BIM_VEC_BANK_BIT]) begin
			vec_q[rif.wr_idx[1:0]] <= rif.wr_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registered read port
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rd_q <= 8'h00;
		end else if (rif.rd_en) begin
			rd_q <= rif.rd_idx[`BIM_VEC_BANK_BIT] ? vec_q[rif.rd_idx[1:0]]
				: ctrl_q[rif.rd_idx[1:0]];
		end
	end

	assign rif.rd_data   = rd_q;
	assign rif.ctrl_flat = {ctrl_q[3], ctrl_q[2], ctrl_q[1], ctrl_q[0]};
	assign rif.vec_flat  = {vec_q[3], vec_q[2], vec_q[1], vec_q[0]};

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	property p_rst_vals;
		rif.soft_rst |=> (vec_q[0] == `BIM_VEC_RST) && (vec_q[3] == `BIM_VEC_RST)
			&& (ctrl_q[0] == `BIM_CTRL_RST) && (ctrl_q[3] == `BIM_CTRL_RST);
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("bus reset values wrong");

	property p_auto_clr;
		rif.ack_clr && !rif.soft_rst && !rif.wr_en && (rif.ack_src == 2'h3)
			&& ctrl_q[3][`BIM_AUTO_CLR_BIT] |=> !ctrl_q[3][`BIM_SRC_EN_BIT];
	endproperty
	a_auto_clr: assert property (p_auto_clr) else $error("enable not auto cleared");
endmodule // bim_regs

//--- bim_top.sv
`timescale 1ns/1ps
`include "bim_consts.svh"
// four-source bus interrupter: register access, requests, acknowledge
module bim_top (
	input  wire logic       mclk,
	input  wire logic       arst_n,
	input  wire logic       cs_n,                  // chip select
	input  wire logic       iack_n,                // acknowledge cycle
	input  wire logic       iackin_n,              // daisy chain in
	input  wire logic       rw,                    // 1 read, 0 write
	input  wire logic [2:0] addr,                  // register index / ack level
	input  wire logic [7:0] data_in,               // data bus in
	input  wire logic [3:0] source_request_n,      // local requests
	output logic      [7:0] data_out,              // data bus out
	output logic            data_oe,               // data bus driven
	output logic            dtack_n,               // acknowledge level
	output logic            dtack_oe,              // acknowledge driven
	output logic      [6:0] irq_n,                 // request lines 1..7
	output logic      [6:0] irq_oe,                // request lines pulled
	output logic            iackout_n,             // daisy chain out
	output logic            ack_external_strobe_n, // acknowledge strobe
	output logic      [1:0] ack_source_code        // source index
);
	bim_reg_if rif ();

	bim_regs u_regs (
		.mclk   (mclk),
		.arst_n (arst_n),
		.rif    (rif)
	);

	////////////////////////////////////////////////////////////////////////////
	// field helpers
	function automatic logic [2:0] f_lvl(input logic [31:0] cf, input int s);
		f_lvl = cf[s*8 + `BIM_LVL_LSB +: `BIM_LVL_W];
	endfunction

	function automatic logic f_en(input logic [31:0] cf, input int s);
		f_en = cf[s*8 + `BIM_SRC_EN_BIT];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// input synchroniser
	logic [`BIM_SYNC_W-1:0] sync1_q; // first stage, read only by stage two
	logic [`BIM_SYNC_W-1:0] sync2_q; // stable samples

	// every bus and request pin arrives from outside the clock
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= `BIM_SYNC_IDLE;
			sync2_q <= `BIM_SYNC_IDLE;
		end else begin
			sync1_q <= {source_request_n, data_in, addr, rw, iackin_n, iack_n, cs_n};
			sync2_q <= sync1_q;
		end
	end

	logic       cs_l;     // select asserted
	logic       iack_l;   // acknowledge asserted
	logic       iackin_l; // daisy in asserted
	logic       rw_s;     // direction
	logic [2:0] addr_s;   // address
	logic [7:0] din_s;    // write data
	logic [3:0] req_s;    // requests, active high
	logic       both_low; // bus reset request

	assign cs_l     = !sync2_q[0];
	assign iack_l   = !sync2_q[1];
	assign iackin_l = !sync2_q[2];
	assign rw_s     = sync2_q[3];
	assign addr_s   = sync2_q[6:4];
	assign din_s    = sync2_q[14:7];
	assign req_s    = ~sync2_q[18:15];
	assign both_low = cs_l && iack_l;

	////////////////////////////////////////////////////////////////////////////
	// bus reset: select and acknowledge low together
	logic both_prev_q; // both low on the previous edge
	logic soft_rst_q;  // reset level to the registers

	// a single-cycle overlap is treated as a glitch, not a reset
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			both_prev_q <= 1'b0;
			soft_rst_q  <= 1'b0;
		end else begin
			both_prev_q <= both_low;
			soft_rst_q  <= both_low && both_prev_q;
		end
	end

	assign rif.soft_rst = soft_rst_q;

	////////////////////////////////////////////////////////////////////////////
	// request lines
	logic [6:0] irq_d; // level wanted per line

	// level zero has no line, so it drops out of the loop
	always_comb begin
		irq_d = 7'h00;
		for (int s = 0; s < 4; s++) begin
			for (int l = 1; l < 8; l++) begin
				if (req_s[s] && f_en(rif.ctrl_flat, s)
					&& (f_lvl(rif.ctrl_flat, s) == l[2:0]))
					irq_d[l-1] = 1'b1;
			end
		end
	end

	// line stays pulled while any enabled source on it still asks
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irq_oe <= 7'h00;
			irq_n  <= 7'h7F;
		end else begin
			irq_oe <= irq_d;
			irq_n  <= ~irq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// acknowledge match: highest numbered source wins
	logic [2:0] lvl_q;  // latched acknowledge level
	logic [3:0] pend_q; // requests frozen at acknowledge start
	logic       hit;    // some source matches
	logic [1:0] hit_src;// winning source

	always_comb begin
		hit     = 1'b0;
		hit_src = 2'h0;
		for (int s = 0; s < 4; s++) begin
			if (pend_q[s] && f_en(rif.ctrl_flat, s) && (f_lvl(rif.ctrl_flat, s) != 3'h0)
				&& (f_lvl(rif.ctrl_flat, s) == lvl_q)) begin
				hit     = 1'b1;
				hit_src = s[1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer
	bim_pkg::bim_state_type state_q; // current state
	logic                   rw_q;    // latched direction
	logic                   ext_q;   // external answer chosen
	logic [1:0]             src_q;   // served source

	// one process owns the state and every bus-facing output except the request lines
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_q               <= bim_pkg::ST_IDLE;
			rw_q                  <= 1'b1;
			ext_q                 <= 1'b0;
			src_q                 <= 2'h0;
			lvl_q                 <= 3'h0;
			pend_q                <= 4'h0;
			rif.wr_en             <= 1'b0;
			rif.wr_idx            <= 3'h0;
			rif.wr_data           <= 8'h00;
			rif.rd_en             <= 1'b0;
			rif.rd_idx            <= 3'h0;
			rif.ack_clr           <= 1'b0;
			rif.ack_src           <= 2'h0;
			data_out              <= 8'h00;
			data_oe               <= 1'b0;
			dtack_n               <= 1'b1;
			dtack_oe              <= 1'b0;
			iackout_n             <= 1'b1;
			ack_external_strobe_n <= 1'b1;
			ack_source_code       <= 2'h0;
		end else begin
			rif.wr_en   <= 1'b0;
			rif.rd_en   <= 1'b0;
			rif.ack_clr <= 1'b0;
			if (both_low) begin
				// reset request: drop every driven line except the request lines
				state_q               <= bim_pkg::ST_IDLE;
				data_oe               <= 1'b0;
				dtack_n               <= 1'b1;
				dtack_oe              <= 1'b0;
				iackout_n             <= 1'b1;
				ack_external_strobe_n <= 1'b1;
			end else begin
				case (state_q)
					bim_pkg::ST_IDLE: begin
						if (cs_l) begin
							// first sample low is the select edge
							rw_q        <= rw_s;
							rif.wr_en   <= !rw_s;
							rif.wr_idx  <= addr_s;
							rif.wr_data <= din_s;
							rif.rd_en   <= rw_s;
							rif.rd_idx  <= addr_s;
							state_q     <= bim_pkg::ST_ACCESS;
						end else if (iack_l) begin
							lvl_q   <= addr_s;
							pend_q  <= req_s;
							state_q <= bim_pkg::ST_WAITIN;
						end
					end
					bim_pkg::ST_ACCESS: begin
						// a read waits one edge while storage loads its read register
						if (!rif.rd_en) begin
							data_out <= rif.rd_data;
							data_oe  <= rw_q;
							dtack_oe <= 1'b1;
							dtack_n  <= 1'b0;
							state_q  <= bim_pkg::ST_ACCDONE;
						end
					end
					bim_pkg::ST_ACCDONE: begin
						if (!cs_l) begin
							data_oe  <= 1'b0;
							dtack_oe <= 1'b0;
							dtack_n  <= 1'b1;
							state_q  <= bim_pkg::ST_IDLE;
						end
					end
					bim_pkg::ST_WAITIN: begin
						if (!iack_l) begin
							state_q <= bim_pkg::ST_IDLE;
						end else if (iackin_l) begin
							if (!hit) begin
								iackout_n <= 1'b0;
								state_q   <= bim_pkg::ST_PASS;
							end else begin
								src_q           <= hit_src;
								ext_q           <= rif.ctrl_flat[hit_src*8 + `BIM_EXT_SEL_BIT];
								ack_source_code <= hit_src;
								rif.ack_clr     <= 1'b1;
								rif.ack_src     <= hit_src;
								state_q         <= bim_pkg::ST_CODE;
							end
						end
					end
					bim_pkg::ST_PASS: begin
						if (!iack_l) begin
							iackout_n <= 1'b1;
							state_q   <= bim_pkg::ST_IDLE;
						end
					end
					bim_pkg::ST_CODE: begin
						// code has stood one cycle before the strobe falls
						ack_external_strobe_n <= 1'b0;
						if (!ext_q) begin
							data_out <= rif.vec_flat[src_q*8 +: 8];
							data_oe  <= 1'b1;
							dtack_oe <= 1'b1;
							dtack_n  <= 1'b0;
						end
						state_q <= bim_pkg::ST_RESPOND;
					end
					bim_pkg::ST_RESPOND: begin
						if (!iack_l) begin
							data_oe               <= 1'b0;
							dtack_oe              <= 1'b0;
							dtack_n               <= 1'b1;
							ack_external_strobe_n <= 1'b1;
							state_q               <= bim_pkg::ST_IDLE;
						end
					end
					default: begin
						state_q <= bim_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	property p_acc_dtack;
		(state_q == bim_pkg::ST_IDLE) && cs_l && !iack_l && !rw_s ##1 !both_low
			|=> dtack_oe && !dtack_n;
	endproperty
	a_acc_dtack: assert property (p_acc_dtack) else $error("no access acknowledge");

	property p_acc_rd;
		(state_q == bim_pkg::ST_IDLE) && cs_l && !iack_l && rw_s ##1 !both_low ##1 !both_low
			|=> dtack_oe && !dtack_n && data_oe;
	endproperty
	a_acc_rd: assert property (p_acc_rd) else $error("no read acknowledge");

	property p_rd_data;
		(state_q == bim_pkg::ST_ACCESS) && rw_q && !rif.rd_en && !both_low
			|=> data_oe && (data_out == $past(rif.rd_data));
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("read data wrong");

	property p_no_iackin;
		(state_q == bim_pkg::ST_WAITIN) && !iackin_l
			|=> !dtack_oe && iackout_n && ack_external_strobe_n && !data_oe;
	endproperty
	a_no_iackin: assert property (p_no_iackin) else $error("answered without daisy in");

	property p_pass;
		(state_q == bim_pkg::ST_WAITIN) && iack_l && iackin_l && !hit && !both_low
			|=> !iackout_n ##1 (!iackout_n || !$past(iack_l) || $past(both_low));
	endproperty
	a_pass: assert property (p_pass) else $error("daisy chain not passed");

	property p_pass_hold;
		!iackout_n && iack_l && !both_low |=> !iackout_n;
	endproperty
	a_pass_hold: assert property (p_pass_hold) else $error("daisy out dropped early");

	property p_int_resp;
		(state_q == bim_pkg::ST_CODE) && !ext_q && !both_low
			|=> dtack_oe && data_oe && iackout_n && !ack_external_strobe_n
			&& (data_out == rif.vec_flat[src_q*8 +: 8]);
	endproperty
	a_int_resp: assert property (p_int_resp) else $error("internal answer wrong");

	property p_ext_resp;
		(state_q == bim_pkg::ST_CODE) && ext_q && !both_low
			|=> !ack_external_strobe_n && !dtack_oe && !data_oe && iackout_n;
	endproperty
	a_ext_resp: assert property (p_ext_resp) else $error("external answer wrong");

	property p_release;
		(state_q == bim_pkg::ST_RESPOND) && !iack_l
			|=> !dtack_oe && !data_oe && ack_external_strobe_n;
	endproperty
	a_release: assert property (p_release) else $error("answer not released");

	property p_prio;
		(state_q == bim_pkg::ST_WAITIN) && iack_l && iackin_l && !both_low && pend_q[3]
			&& f_en(rif.ctrl_flat, 3) && (f_lvl(rif.ctrl_flat, 3) == lvl_q)
			&& (lvl_q != 3'h0) |=> (src_q == 2'h3) && (ack_source_code == 2'h3);
	endproperty
	a_prio: assert property (p_prio) else $error("priority order wrong");

	property p_bus_rst;
		both_low ##1 both_low |=> soft_rst_q;
	endproperty
	a_bus_rst: assert property (p_bus_rst) else $error("bus reset missed");
endmodule // bim_top

//--- bim_host.sv
`timescale 1ns/1ps
// bus master model: register access, acknowledge cycles, bus reset
module bim_host (
	output logic            cs_n,
	output logic            iack_n,
	output logic            iackin_n,
	output logic            rw,
	output logic      [2:0] addr,
	output logic      [7:0] data_in,
	input  wire logic       mclk,
	input  wire logic [7:0] data_out,
	input  wire logic       dtack_n,
	input  wire logic       dtack_oe
);
	// idle bus: nothing selected
	initial begin
		cs_n = 1'b1;
		iack_n = 1'b1;
		iackin_n = 1'b1;
		rw = 1'b1;
		addr = 3'h0;
		data_in = 8'h00;
	end

	////////////////////////////////////////
	// one access; held until acknowledge seen on a rising edge
	task automatic acc(input logic r, input logic [2:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic ok);
		int n;
		ok = 1'b0;
		@(negedge mclk);
		rw = r;
		addr = a;
		data_in = d;
		cs_n = 1'b0;
		for (n = 0; n < 20 && ok !== 1'b1; n++) begin
			@(posedge mclk);
			ok = dtack_oe && !dtack_n;
		end
		q = data_out;
		@(negedge mclk);
		cs_n = 1'b1;
		// released lines do not keep their last value
		addr = ~a;
		data_in = ~d;
		repeat (6) @(negedge mclk);
	endtask

	// open an acknowledge cycle at a level, daisy input as asked
	task automatic iack_start(input logic [2:0] lvl, input logic chain);
		@(negedge mclk);
		rw = 1'b1;
		addr = lvl;
		iack_n = 1'b0;
		iackin_n = !chain;
		repeat (8) @(negedge mclk);
	endtask

	// close it; called at a falling edge
	task automatic iack_end();
		iack_n = 1'b1;
		iackin_n = 1'b1;
		addr = ~addr;
		repeat (6) @(negedge mclk);
	endtask

	// both strobes low well beyond the two-cycle minimum
	task automatic brst();
		@(negedge mclk);
		cs_n = 1'b0;
		iack_n = 1'b0;
		repeat (6) @(negedge mclk);
		cs_n = 1'b1;
		iack_n = 1'b1;
		repeat (6) @(negedge mclk);
	endtask
endmodule // bim_host

//--- bus_interrupter_module_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
	$display("BAD %0t got %h exp %h", $time, (a), (b)); end end
// self-checking bench for the four-source interrupter
module bus_interrupter_module_tb;
	typedef struct {
		logic [7:0] ctrl;
		logic       req;
		logic [6:0] irq;
	} bim_row_type;

	logic        mclk;
	logic        arst_n;
	logic [3:0]  req_n;
	logic        cs_n;
	logic        iack_n;
	logic        iackin_n;
	logic        rw;
	logic [2:0]  addr;
	logic [7:0]  data_in;
	logic [7:0]  data_out;
	logic        data_oe;
	logic        dtack_n;
	logic        dtack_oe;
	logic [6:0]  irq_n;
	logic [6:0]  irq_oe;
	logic        iackout_n;
	logic        strb_n;
	logic [1:0]  code;
	logic [7:0]  q;
	logic        ok;
	int          i;
	int          comparisons;
	int          miscompares;
	bim_row_type rows [12];

	bim_top dut (
		.mclk(mclk),
		.arst_n(arst_n),
		.cs_n(cs_n),
		.iack_n(iack_n),
		.iackin_n(iackin_n),
		.rw(rw),
		.addr(addr),
		.data_in(data_in),
		.source_request_n(req_n),
		.data_out(data_out),
		.data_oe(data_oe),
		.dtack_n(dtack_n),
		.dtack_oe(dtack_oe),
		.irq_n(irq_n),
		.irq_oe(irq_oe),
		.iackout_n(iackout_n),
		.ack_external_strobe_n(strb_n),
		.ack_source_code(code)
	);

	bim_host host (
		.cs_n(cs_n),
		.iack_n(iack_n),
		.iackin_n(iackin_n),
		.rw(rw),
		.addr(addr),
		.data_in(data_in),
		.mclk(mclk),
		.data_out(data_out),
		.dtack_n(dtack_n),
		.dtack_oe(dtack_oe)
	);

	////////////////////////////////////////
	// 250 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		host.acc(1'b0, a, d, q, ok);
		`CHK(ok, 1'b1)
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		host.acc(1'b1, a, 8'h00, q, ok);
		`CHK(ok, 1'b1)
		`CHK(q, e)
	endtask

	task automatic final_report();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		#100000;
		miscompares++;
		final_report();
	end

	////////////////////////////////////////
	initial begin
		comparisons = 0;
		miscompares = 0;
		arst_n = 1'b0;
		req_n = 4'hF;
		// every level once, then the odd cases
		for (i = 0; i < 7; i++) begin
			rows[i] = '{8'h11 + i[7:0], 1'b1, 7'h01 << i};
		end
		rows[7] = '{8'h03, 1'b1, 7'h00};
		rows[8] = '{8'h10, 1'b1, 7'h00};
		rows[9] = '{8'h97, 1'b1, 7'h40};
		rows[10] = '{8'hD3, 1'b1, 7'h04};
		rows[11] = '{8'h17, 1'b0, 7'h00};
		repeat (16) @(negedge mclk);
		arst_n = 1'b1;
		repeat (4) @(negedge mclk);
		`CHK({irq_oe, irq_n}, 14'h007F)
		`CHK({dtack_oe, data_oe, iackout_n, strb_n}, 4'h3)
		for (i = 0; i < 8; i++) begin
			rd(i[2:0], i < 4 ? 8'h00 : 8'h0F);
		end
		// request line decoding, one row at a time
		for (i = 0; i < 12; i++) begin
			wr(3'h0, rows[i].ctrl);
			req_n[0] = !rows[i].req;
			repeat (8) @(negedge mclk);
			`CHK(irq_oe, rows[i].irq)
			`CHK(irq_n, ~rows[i].irq)
		end
		rd(3'h0, 8'h17);
		for (i = 0; i < 4; i++) begin
			wr(3'h4 + i[2:0], 8'hA0 + i[7:0]);
			rd(3'h4 + i[2:0], 8'hA0 + i[7:0]);
		end
		// sources 1 and 3 share level 5; 3 clears its own enable
		wr(3'h0, 8'h00);
		wr(3'h1, 8'h15);
		wr(3'h3, 8'h1D);
		req_n = 4'h5;
		repeat (8) @(negedge mclk);
		for (i = 0; i < 2; i++) begin
			`CHK(irq_oe, 7'h10)
			host.iack_start(3'h5, 1'b1);
			`CHK(dtack_oe & ~dtack_n & data_oe, 1'b1)
			`CHK(data_out, i == 0 ? 8'hA3 : 8'hA1)
			`CHK(code, i == 0 ? 2'h3 : 2'h1)
			`CHK({strb_n, iackout_n}, 2'h1)
			host.iack_end();
			`CHK({dtack_oe, data_oe, strb_n}, 3'h1)
		end
		rd(3'h3, 8'h0D);
		// daisy input never arrives: silence
		host.iack_start(3'h5, 1'b0);
		`CHK({dtack_oe, data_oe, iackout_n, strb_n}, 4'h3)
		host.iack_end();
		// no match at level 2: pass on and hold
		host.iack_start(3'h2, 1'b1);
		`CHK({iackout_n, dtack_oe, data_oe}, 3'h0)
		repeat (4) @(negedge mclk);
		`CHK(iackout_n, 1'b0)
		host.iack_end();
		`CHK(iackout_n, 1'b1)
		// external answer with flag auto clear on source 2
		req_n = 4'hF;
		wr(3'h1, 8'h00);
		wr(3'h2, 8'hF6);
		req_n = 4'hB;
		repeat (8) @(negedge mclk);
		host.iack_start(3'h6, 1'b1);
		`CHK({dtack_oe, data_oe, iackout_n, strb_n}, 4'h2)
		`CHK(code, 2'h2)
		repeat (4) @(negedge mclk);
		// strobe and code stand for the outside responder until the cycle ends
		`CHK({strb_n, code, dtack_oe}, 4'h4)
		host.iack_end();
		rd(3'h2, 8'h76);
		// request arriving after the cycle began is not seen
		req_n = 4'hF;
		wr(3'h2, 8'h00);
		wr(3'h0, 8'h14);
		fork
			host.iack_start(3'h4, 1'b1);
			begin
				repeat (2) @(negedge mclk);
				req_n[0] = 1'b0;
			end
		join
		`CHK({iackout_n, dtack_oe}, 2'h0)
		host.iack_end();
		`CHK(irq_oe, 7'h08)
		// bus-made reset
		host.brst();
		`CHK(irq_oe, 7'h00)
		rd(3'h4, 8'h0F);
		rd(3'h0, 8'h00);
		final_report();
	end
endmodule // bus_interrupter_module_tb
